// [rocof_pkg.sv]
package rocof_pkg;

    // measured quantities: rocof_stage in mHz/s (0.001 Hz/s step), frequency in 10 mHz
    localparam int RATE_W     = 16;
    localparam int FREQ_W     = 14;
    localparam int TIME_W     = 20;   // ms, up to 1048 s
    localparam int RATIO_W    = 16;   // ratio in 0.005 p.u. steps
    localparam int STAMP_W    = 48;
    localparam int GROUP_W    = 3;

    // timing
    localparam int CLK_MHZ          = 125;
    localparam int CYCLE_MS         = 5;          // program cycle time base
    localparam int CYCLE_CLKS       = CYCLE_MS * 1000 * CLK_MHZ;
    localparam int PRETRIG_MS       = 20;
    localparam int PRETRIG_CYCLES   = PRETRIG_MS / CYCLE_MS;
    localparam int TIME_STEP_MS     = 5;          // remaining / expected time step
    localparam int RATIO_STEP_MPU   = 5;          // 0.005 p.u.

    // fixed hysteresis and defaults, mHz/s and 10 mHz
    localparam logic [RATE_W-1:0] HYST_MHZS      = 16'h0064;  // 100 mHz/s
    localparam logic [RATE_W-1:0] MAX_RATE_RST   = 16'h4e20;  // 20 Hz/s
    localparam logic [RATE_W-1:0] PICKUP_RST     = 16'h00c8;  // 0.2 Hz/s
    localparam logic [FREQ_W-1:0] F_UNDER_RST    = 14'h1383;  // 49.95 Hz
    localparam logic [FREQ_W-1:0] F_OVER_RST     = 14'h13ec;  // 51 Hz

    // record store
    localparam int REC_DEPTH = 12;
    localparam int REC_PTR_W = 4;
    localparam int CNT_W     = 16;

    typedef enum logic [1:0]
    {
        COND_NORMAL  = 2'b00,
        COND_STARTED = 2'b01,
        COND_TRIPPED = 2'b10,
        COND_BLOCKED = 2'b11
    } cond_e;

    typedef enum logic [1:0]
    {
        MODE_RISING  = 2'b00,
        MODE_FALLING = 2'b01,
        MODE_BOTH    = 2'b10
    } mode_e;

    // event kinds: start/trip/blocked, on/off
    typedef enum logic [2:0]
    {
        EV_START_ON  = 3'b000,
        EV_START_OFF = 3'b001,
        EV_TRIP_ON   = 3'b010,
        EV_TRIP_OFF  = 3'b011,
        EV_BLK_ON    = 3'b100,
        EV_BLK_OFF   = 3'b101
    } event_e;

    // event mask: bit0 on events, bit1 off events
    typedef struct packed
    {
        logic [7:0]         tag;
        event_e             kind;
        logic [STAMP_W-1:0] stamp;
    } event_s;

    typedef struct packed
    {
        logic [STAMP_W-1:0]      stamp;
        event_e                  kind;
        logic signed [RATE_W:0]  pre_rate;
        logic [FREQ_W-1:0]       pre_freq;
        logic signed [RATE_W:0]  flt_rate;
        logic [FREQ_W-1:0]       flt_freq;
        logic [GROUP_W-1:0]      group;
    } record_s;

    typedef struct packed
    {
        logic                     pickup_en;
        mode_e                    mode;
        logic                     flim_en;
        logic [RATE_W-1:0]        pickup;
        logic [FREQ_W-1:0]        f_under;
        logic [FREQ_W-1:0]        f_over;
        logic [RATE_W-1:0]        max_rate;
        logic [TIME_W-1:0]        delay_ms;
        logic [GROUP_W-1:0]       group;
    } config_s;

endpackage

// [rocof_stage.sv]
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: publish present rocof_stage as read-only value, 0.001 Hz/s resolution.
// R2: condition is one of normal, started, tripped, blocked.
// R3: publish measured/pick-up ratio in 0.005 p.u. steps.
// R4: publish expected operating time, 5 ms resolution.
// R5: publish signed remaining time counting down toward trip.
// R6: sample the blocking input at the start of each program cycle.
// R7: pick-up without blocking asserts start and begins operate timing.
// R8: pick-up with blocking asserts blocked, never start or trip.
// R9: blocking after start clears start and runs release as on drop-out.
// R10: blocking source must assert it 5 ms before the delay expires.
// R11: each start/trip/blocked change makes on or off event with tag.
// R12: user mask selects on events, off events or both for forwarding.
// R13: every event carries a time stamp.
// R14: separate clearable counters for start, trip and blocked.
// R15: circular store of twelve most recent records, oldest overwritten.
// R16: record holds stamp, event, pre-trigger and fault rocof_stage, frequency, group.
// R17: start, trip and blocked are plain binary outputs.
// R18: pick up above setting, release 100 mHz/s below it.
// R19: mode restricts tripping to rising, falling or both; default rising.
// R20: with limits on, trip only below under- or above over-frequency limit.
// R21: held blocked while rocof_stage exceeds maximum allowed rate.
// R22: definite delay counts program cycles while started, trips at setting.
module rocof_stage
#(
    parameter int  CYCLE_CLKS = rocof_pkg::CYCLE_CLKS,
    parameter logic [7:0] rocof_event_tag = 8'h01  // arbitrary block identifier
)
(
    // clock and reset
    input  wire logic                                   i_clk,
    input  wire logic                                   i_rst_n,
    // frequency tracking unit
    input  wire logic signed [rocof_pkg::RATE_W:0]      i_rate,
    input  wire logic [rocof_pkg::FREQ_W-1:0]           i_freq,
    input  wire logic [rocof_pkg::STAMP_W-1:0]          i_stamp,
    // blocking matrix
    input  wire logic                                   i_block,
    // settings and counter clears (start, trip, blocked)
    input  wire rocof_pkg::config_s                     i_cfg,
    input  wire logic [1:0]                             i_ev_mask,
    input  wire logic [2:0]                             i_cnt_clr,
    // record read port
    input  wire logic [rocof_pkg::REC_PTR_W-1:0]        i_rec_idx,
    output var rocof_pkg::record_s                      o_rec,
    // status
    output logic [rocof_pkg::RATE_W:0]                  o_rate,
    output logic [1:0]                                  o_cond,
    output logic [rocof_pkg::RATIO_W-1:0]               o_ratio,
    output logic [rocof_pkg::TIME_W-1:0]                o_expect_ms,
    output logic signed [rocof_pkg::TIME_W:0]           o_remain_ms,
    // binary outputs
    output logic                                        o_start,
    output logic                                        o_trip,
    output logic                                        o_blocked,
    // event buffer
    output logic                                        o_ev_valid,
    output var rocof_pkg::event_s                       o_ev,
    // counters
    output logic [rocof_pkg::CNT_W-1:0]                 o_cnt_start,
    output logic [rocof_pkg::CNT_W-1:0]                 o_cnt_trip,
    output logic [rocof_pkg::CNT_W-1:0]                 o_cnt_blk
);

    localparam int RW = rocof_pkg::RATE_W;
    localparam int HW = 4;  // pre-trigger history depth

    typedef struct packed
    {
        logic [31:0]                    div;
        rocof_pkg::cond_e               cond;
        logic                           start;
        logic                           trip;
        logic                           blocked;
        logic [rocof_pkg::TIME_W-1:0]   elapsed;
        logic [RW:0]                    rate_out;
        logic [rocof_pkg::RATIO_W-1:0]  ratio;
        logic [rocof_pkg::TIME_W-1:0]   expect_ms;
        logic signed [rocof_pkg::TIME_W:0] remain;
        logic [HW-1:0][RW:0]            hist_rate;
        logic [HW-1:0][rocof_pkg::FREQ_W-1:0] hist_freq;
        logic [5:0]                     ev_pend;
        logic                           ev_valid;
        rocof_pkg::event_s              ev;
        logic [rocof_pkg::CNT_W-1:0]    cnt_start;
        logic [rocof_pkg::CNT_W-1:0]    cnt_trip;
        logic [rocof_pkg::CNT_W-1:0]    cnt_blk;
        logic [rocof_pkg::REC_PTR_W-1:0] wr_ptr;
        logic                           rec_we;
        rocof_pkg::record_s             rec_new;
    } state_s;

    state_s st_q;
    state_s st_d;
    rocof_pkg::record_s rec_mem [rocof_pkg::REC_DEPTH];
    rocof_pkg::record_s rec_rd_q;

    // absolute value of a signed rate
    function automatic logic [RW-1:0] mag(input logic signed [RW:0] r);
        logic [RW:0] t;
        t = r[RW] ? 17'(-r) : 17'(r);
        return t[RW-1:0];
    endfunction

    // saturating counter step
    function automatic logic [rocof_pkg::CNT_W-1:0] bump(
        input logic [rocof_pkg::CNT_W-1:0] c, input logic inc, input logic clr);
        logic [rocof_pkg::CNT_W-1:0] n;
        n = c;
        if (inc && c != '1)
            n = c + 16'h0001;
        // an occurrence in the clear cycle survives as a count of one
        if (clr)
            n = inc ? 16'h0001 : 16'h0000;
        return n;
    endfunction

    logic [RW-1:0] abs_rate;
    logic          dir_ok;
    logic          freq_ok;
    logic          over_max;
    logic          above_pu;
    logic          below_rel;
    logic          tick;
    logic [5:0]    ev_chg;
    logic [2:0]    ev_sel;

    always_comb
    begin
        abs_rate  = mag(i_rate);
        above_pu  = abs_rate > i_cfg.pickup;
        below_rel = ({1'b0, abs_rate} + {1'b0, rocof_pkg::HYST_MHZS}) < {1'b0, i_cfg.pickup};
        over_max  = abs_rate > i_cfg.max_rate;
        tick      = st_q.div == 32'(CYCLE_CLKS - 1);
        ev_chg    = '0;
        ev_sel    = '0;
        // R19: direction filter by mode
        case (i_cfg.mode)
            rocof_pkg::MODE_RISING:  dir_ok = !i_rate[RW];
            rocof_pkg::MODE_FALLING: dir_ok = i_rate[RW];
            rocof_pkg::MODE_BOTH:    dir_ok = 1'b1;
            default:                 dir_ok = 1'b0;
        endcase
        // R20: frequency window gate
        freq_ok = !i_cfg.flim_en || (i_freq < i_cfg.f_under) || (i_freq > i_cfg.f_over);

        st_d        = st_q;
        st_d.div    = tick ? 32'h0 : st_q.div + 32'h1;
        st_d.ev_valid = 1'b0;
        st_d.rec_we = 1'b0;

        // R6: blocking input read only at the cycle tick
        if (tick)
        begin
            // R1: published rocof_stage refreshed every cycle
            st_d.rate_out = i_rate;
            st_d.hist_rate = {st_q.hist_rate[HW-2:0], i_rate};
            st_d.hist_freq = {st_q.hist_freq[HW-2:0], i_freq};
            // R3: ratio in 0.005 p.u. steps, 0 when pick-up is zero
            st_d.ratio = (i_cfg.pickup == '0) ? '0 : 16'((32'(abs_rate) * 32'd200)
                         / 32'(i_cfg.pickup));
            // R4: expected operating time equals the definite delay
            st_d.expect_ms = i_cfg.delay_ms;

            if (!i_cfg.pickup_en)
            begin
                st_d.start   = 1'b0;
                st_d.trip    = 1'b0;
                st_d.blocked = 1'b0;
                st_d.elapsed = '0;
            end
            // R8: R21: blocking or over-rate pick-up stays blocked only
            else if ((over_max || (i_block && above_pu && dir_ok)) && !st_q.start)
            begin
                st_d.blocked = 1'b1;
                st_d.trip    = 1'b0;
            end
            // R9: block after start resets like a drop-out
            else if (st_q.start && (i_block || over_max || below_rel || !dir_ok))
            begin
                st_d.start   = 1'b0;
                st_d.trip    = 1'b0;
                st_d.elapsed = '0;
                st_d.blocked = i_block || over_max;
            end
            // R7: pick-up without block starts timing
            else if (!st_q.start && above_pu && dir_ok)
            begin
                st_d.start   = 1'b1;
                st_d.blocked = 1'b0;
                st_d.elapsed = '0;
            end
            // R18: blocked clears when pick-up releases
            else if (!st_q.start && below_rel)
                st_d.blocked = 1'b0;

            // R22: definite delay advances one cycle step
            if (st_q.start && st_d.start)
            begin
                if (st_q.elapsed < i_cfg.delay_ms)
                    st_d.elapsed = st_q.elapsed + 20'(rocof_pkg::CYCLE_MS);
                // R20: trip allowed only outside frequency window
                if (st_d.elapsed >= i_cfg.delay_ms && freq_ok)
                    st_d.trip = 1'b1;
            end
            // R5: signed remaining time
            st_d.remain = st_d.start ? (21'(i_cfg.delay_ms) - 21'(st_d.elapsed)) : 21'(0);
        end

        // R2: one encoded condition, blocked ranks first
        st_d.cond = st_d.blocked ? rocof_pkg::COND_BLOCKED :
                    st_d.trip    ? rocof_pkg::COND_TRIPPED :
                    st_d.start   ? rocof_pkg::COND_STARTED : rocof_pkg::COND_NORMAL;

        // R11: on/off change detection, one bit per event kind
        ev_chg = { !st_d.blocked &&  st_q.blocked,  st_d.blocked && !st_q.blocked,
                   !st_d.trip    &&  st_q.trip,     st_d.trip    && !st_q.trip,
                   !st_d.start   &&  st_q.start,    st_d.start   && !st_q.start };
        // R12: mask keeps on (even) and off (odd) kinds
        ev_chg = ev_chg & {3{i_ev_mask[1], i_ev_mask[0]}};

        // R14: counters bump on on-transitions
        st_d.cnt_start = bump(st_q.cnt_start, ev_chg[0] | (st_d.start & !st_q.start), i_cnt_clr[0]);
        st_d.cnt_trip  = bump(st_q.cnt_trip,  st_d.trip & !st_q.trip,       i_cnt_clr[1]);
        st_d.cnt_blk   = bump(st_q.cnt_blk,   st_d.blocked & !st_q.blocked, i_cnt_clr[2]);

        // R15: R16: record on start, trip or blocked on
        if ((st_d.start & !st_q.start) | (st_d.trip & !st_q.trip) | (st_d.blocked & !st_q.blocked))
        begin
            st_d.rec_we           = 1'b1;
            st_d.rec_new.stamp    = i_stamp;
            st_d.rec_new.kind     = (st_d.trip & !st_q.trip) ? rocof_pkg::EV_TRIP_ON :
                                    (st_d.start & !st_q.start) ? rocof_pkg::EV_START_ON :
                                    rocof_pkg::EV_BLK_ON;
            st_d.rec_new.pre_rate = st_q.hist_rate[rocof_pkg::PRETRIG_CYCLES-1];
            st_d.rec_new.pre_freq = st_q.hist_freq[rocof_pkg::PRETRIG_CYCLES-1];
            st_d.rec_new.flt_rate = i_rate;
            st_d.rec_new.flt_freq = i_freq;
            st_d.rec_new.group    = i_cfg.group;
        end
        if (st_q.rec_we)
            st_d.wr_ptr = (st_q.wr_ptr == 4'(rocof_pkg::REC_DEPTH - 1)) ? '0
                          : st_q.wr_ptr + 4'h1;

        // pending events drained one per clock; a new change never erases one
        st_d.ev_pend = st_q.ev_pend | ev_chg;
        for (int k = 5; k >= 0; k--)
            if (st_q.ev_pend[k])
                ev_sel = 3'(k);
        if (st_q.ev_pend != '0)
        begin
            // R13: R11: stamped event with block tag
            st_d.ev_valid    = 1'b1;
            st_d.ev.tag      = rocof_event_tag;
            st_d.ev.kind     = rocof_pkg::event_e'(ev_sel);
            st_d.ev.stamp    = i_stamp;
            st_d.ev_pend[ev_sel] = ev_chg[ev_sel];
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    // record ring: array written one word a time, read registered
    always_ff @(posedge i_clk)
    begin
        if (st_q.rec_we)
            rec_mem[st_q.wr_ptr] <= st_q.rec_new;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rec_rd_q <= '0;
        else if (i_rec_idx < 4'(rocof_pkg::REC_DEPTH))
            rec_rd_q <= rec_mem[i_rec_idx];
        else
            rec_rd_q <= '0;
    end

    // R2: R17: outputs straight from state flops
    assign o_cond      = st_q.cond;
    assign o_start     = st_q.start;
    assign o_trip      = st_q.trip;
    assign o_blocked   = st_q.blocked;
    assign o_rate      = st_q.rate_out;
    assign o_ratio     = st_q.ratio;
    assign o_expect_ms = st_q.expect_ms;
    assign o_remain_ms = st_q.remain;
    assign o_ev_valid  = st_q.ev_valid;
    assign o_ev        = st_q.ev;
    assign o_cnt_start = st_q.cnt_start;
    assign o_cnt_trip  = st_q.cnt_trip;
    assign o_cnt_blk   = st_q.cnt_blk;
    assign o_rec       = rec_rd_q;

    // assertions
    AST_TRIP_NEEDS_START: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.trip |-> st_q.start) else $error("trip without start"); // R22
    AST_BLOCK_EXCLUSIVE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.blocked |-> !st_q.trip) else $error("blocked and tripped"); // R8
    AST_START_ON_TICK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(st_q.start) |-> $past(tick)) else $error("start off cycle"); // R6
    AST_NO_START_BLOCKED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick && i_block && !st_q.start) |=> !st_q.start) else $error("started under block"); // R8
    AST_BLOCK_DROPS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick && i_block && st_q.start && i_cfg.pickup_en) |=> !st_q.start)
        else $error("start kept under block"); // R9
    AST_EVENT_AFTER_TRIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($rose(st_q.trip) && i_ev_mask[0]) |-> ##[0:6] (o_ev_valid && o_ev.kind == rocof_pkg::EV_TRIP_ON))
        else $error("trip on event missing"); // R11
    AST_MASK_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ev_mask == 2'b00 && st_q.ev_pend == '0) |=> !o_ev_valid) else $error("masked event sent"); // R12
    AST_TAGGED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_ev_valid |-> o_ev.tag == rocof_event_tag) else $error("bad event tag"); // R11
    AST_PTR_RANGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.wr_ptr < 4'(rocof_pkg::REC_DEPTH)) else $error("record pointer out of range"); // R15
    AST_CNT_TRIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($rose(st_q.trip) && !$past(i_cnt_clr[1]) && $past(st_q.cnt_trip) != '1)
        |-> st_q.cnt_trip == $past(st_q.cnt_trip) + 16'h1) else $error("trip count missed"); // R14
    AST_OVER_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tick && over_max && i_cfg.pickup_en) |=> (st_q.blocked && !st_q.start))
        else $error("over-rate not blocked"); // R21

    COV_TRIP:    cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(st_q.trip));
    COV_BLOCK:   cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(st_q.blocked));
    COV_RELEASE: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(st_q.start));
    COV_OVERMAX: cover property (@(posedge i_clk) disable iff (!i_rst_n) tick && over_max);
    COV_WRAP:    cover property (@(posedge i_clk) disable iff (!i_rst_n)
        st_q.rec_we && st_q.wr_ptr == 4'(rocof_pkg::REC_DEPTH - 1));

endmodule

`default_nettype wire

// [rocof_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// behavioural frequency tracker and blocking matrix, updated once per clock
module rocof_partner
(
    // clock
    input  wire logic                               i_clk,
    // requested measurement and block level
    input  wire logic signed [rocof_pkg::RATE_W:0]  i_rate_req,
    input  wire logic [rocof_pkg::FREQ_W-1:0]       i_freq_req,
    input  wire logic                               i_block_req,
    // toward the stage
    output logic signed [rocof_pkg::RATE_W:0]       o_rate = '0,
    output logic [rocof_pkg::FREQ_W-1:0]            o_freq = '0,
    output logic [rocof_pkg::STAMP_W-1:0]           o_stamp = 48'h000000000001,
    output logic                                    o_block = 1'b0
);

    // values move one clock late, like a tracker that refreshes on its own beat
    always @(negedge i_clk)
    begin
        o_rate  <= i_rate_req;
        o_freq  <= i_freq_req;
        o_stamp <= o_stamp + 48'h000000000001;
        o_block <= i_block_req;
    end

endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    logic                              clk;
    logic                              rst_n;
    logic signed [rocof_pkg::RATE_W:0] rate_req;
    logic [rocof_pkg::FREQ_W-1:0]      freq_req;
    logic                              blk_req;
    logic signed [rocof_pkg::RATE_W:0] rate;
    logic [rocof_pkg::FREQ_W-1:0]      freq;
    logic [rocof_pkg::STAMP_W-1:0]     stamp;
    logic                              blk;
    rocof_pkg::config_s                cfg;
    logic [1:0]                        ev_mask;
    logic [2:0]                        cnt_clr;
    logic [3:0]                        rec_idx;
    rocof_pkg::record_s                rec;
    logic [16:0]                       o_rate;
    logic [1:0]                        o_cond;
    logic [15:0]                       o_ratio;
    logic [19:0]                       o_expect_ms;
    logic signed [20:0]                o_remain_ms;
    logic                              o_start;
    logic                              o_trip;
    logic                              o_blocked;
    logic                              ev_valid;
    rocof_pkg::event_s                 ev;
    logic [15:0]                       cnt_s;
    logic [15:0]                       cnt_t;
    logic [15:0]                       cnt_b;
    logic [2:0]                        ev_q[$];
    int                                n_fail = 0;
    int                                cmp_count = 0;

    rocof_partner i_partner (.i_clk(clk), .i_rate_req(rate_req), .i_freq_req(freq_req),
        .i_block_req(blk_req), .o_rate(rate), .o_freq(freq), .o_stamp(stamp), .o_block(blk));

    // short program cycle keeps the run brief
    rocof_stage #(.CYCLE_CLKS(8)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_rate(rate),
        .i_freq(freq), .i_stamp(stamp), .i_block(blk), .i_cfg(cfg), .i_ev_mask(ev_mask),
        .i_cnt_clr(cnt_clr), .i_rec_idx(rec_idx), .o_rec(rec), .o_rate(o_rate),
        .o_cond(o_cond), .o_ratio(o_ratio), .o_expect_ms(o_expect_ms),
        .o_remain_ms(o_remain_ms), .o_start(o_start), .o_trip(o_trip),
        .o_blocked(o_blocked), .o_ev_valid(ev_valid), .o_ev(ev), .o_cnt_start(cnt_s),
        .o_cnt_trip(cnt_t), .o_cnt_blk(cnt_b));

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("TB: %0d mismatches in %0d comparisons", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bounded wait; a hang ends the run
    task automatic wait_cond(input logic [1:0] c);
        int n;
        n = 0;
        while (o_cond !== c && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        check("cond_wait", o_cond, c);
        if (o_cond !== c)
            report_and_stop;
    endtask

    // collect forwarded events mid-cycle, where the pulse is settled
    always @(negedge clk)
    begin
        if (ev_valid === 1'b1)
        begin
            ev_q.push_back(ev.kind);
            check("ev_tag", ev.tag, 8'h01);
            check("ev_stamped", ev.stamp !== '0, 1);
        end
    end

    // kinds listed oldest in the low bits
    task automatic ev_expect(input int n, input logic [17:0] kinds);
        repeat (4) @(negedge clk);
        check("ev_count", ev_q.size(), n);
        for (int i = 0; i < n && i < ev_q.size(); i++)
            check("ev_kind", ev_q[i], kinds[3*i+:3]);
        ev_q.delete();
    endtask

    task s_reset;
        check("cond_rst", o_cond, rocof_pkg::COND_NORMAL);
        check("start_rst", o_start, 0);
        check("cnt_rst", cnt_s, 0);
    endtask

    task s_start_trip;
        rate_req = -17'sd500;
        repeat (20) @(negedge clk);
        check("start_falling", o_start, 0);
        rate_req = 17'sd500;
        wait_cond(rocof_pkg::COND_STARTED);
        check("rate", o_rate, 500);
        check("ratio", o_ratio, 500);
        check("expect", o_expect_ms, 10);
        check("remain0", o_remain_ms, 10);
        check("cnt_start", cnt_s, 1);
        repeat (8) @(negedge clk);
        check("remain1", o_remain_ms, 5);
        repeat (7) @(negedge clk);
        check("trip_early", o_trip, 0);
        @(negedge clk);
        check("trip", o_trip, 1);
        check("cond_trip", o_cond, rocof_pkg::COND_TRIPPED);
        check("cnt_trip", cnt_t, 1);
        ev_expect(2, {12'h0, 3'h2, 3'h0});
        rec_idx = 4'h0;
        repeat (2) @(negedge clk);
        check("rec0_kind", rec.kind, rocof_pkg::EV_START_ON);
        check("rec0_group", rec.group, 3);
        check("rec0_rate", rec.flt_rate, 500);
        rec_idx = 4'h1;
        repeat (2) @(negedge clk);
        check("rec1_kind", rec.kind, rocof_pkg::EV_TRIP_ON);
        check("rec1_pre_rate", rec.pre_rate, -500);
        check("rec1_pre_freq", rec.pre_freq, 14'h1388);
    endtask

    // off events masked out while releasing
    task s_release;
        ev_mask = 2'b01;
        rate_req = 17'sd150;
        repeat (20) @(negedge clk);
        check("hyst_hold", o_start, 1);
        rate_req = 17'sd0;
        wait_cond(rocof_pkg::COND_NORMAL);
        check("trip_rel", o_trip, 0);
        ev_expect(0, 18'h0);
        ev_mask = 2'b11;
    endtask

    task s_block;
        cfg.delay_ms = 20'h00064;
        blk_req = 1'b1;
        rate_req = 17'sd500;
        wait_cond(rocof_pkg::COND_BLOCKED);
        check("blk_nostart", o_start, 0);
        blk_req = 1'b0;
        wait_cond(rocof_pkg::COND_STARTED);
        check("blk_off", o_blocked, 0);
        blk_req = 1'b1;
        wait_cond(rocof_pkg::COND_BLOCKED);
        check("start_cleared", o_start, 0);
        ev_expect(5, {3'h0, 3'h4, 3'h1, 3'h5, 3'h0, 3'h4});
        check("cnt_blk", cnt_b, 2);
        blk_req = 1'b0;
        rate_req = 17'sd21000;
        repeat (20) @(negedge clk);
        check("max_rate_blk", o_blocked, 1);
        check("max_rate_nostart", o_start, 0);
        rate_req = 17'sd0;
        wait_cond(rocof_pkg::COND_NORMAL);
        ev_expect(1, 18'h5);
    endtask

    // inside the frequency window the stage starts but holds off the trip
    task s_window;
        cfg.flim_en = 1'b1;
        cfg.delay_ms = 20'h0;
        ev_mask = 2'b10;
        rate_req = 17'sd500;
        wait_cond(rocof_pkg::COND_STARTED);
        repeat (20) @(negedge clk);
        check("win_hold", o_trip, 0);
        freq_req = 14'h1450;
        wait_cond(rocof_pkg::COND_TRIPPED);
        rate_req = 17'sd0;
        wait_cond(rocof_pkg::COND_NORMAL);
        ev_expect(2, {12'h0, 3'h3, 3'h1});
        ev_mask = 2'b00;
    endtask

    task s_clear;
        cnt_clr = 3'h7;
        repeat (2) @(negedge clk);
        cnt_clr = 3'h0;
        check("clr_s", cnt_s, 0);
        check("clr_t", cnt_t, 0);
        check("clr_b", cnt_b, 0);
    endtask

    initial
    begin
        rst_n = 1'b0;
        rate_req = '0;
        freq_req = 14'h1388;
        blk_req = 1'b0;
        cfg = '0;
        cfg.pickup_en = 1'b1;
        cfg.mode = rocof_pkg::MODE_RISING;
        cfg.pickup = 16'h00c8;
        cfg.f_under = 14'h1383;
        cfg.f_over = 14'h13ec;
        cfg.max_rate = 16'h4e20;
        cfg.delay_ms = 20'h0000a;
        cfg.group = 3'h3;
        ev_mask = 2'b11;
        cnt_clr = 3'h0;
        rec_idx = 4'h0;
        repeat (3) @(negedge clk);
        s_reset();
        rst_n = 1'b1;
        s_start_trip();
        s_release();
        s_block();
        s_window();
        s_clear();
        report_and_stop();
    end

endmodule

`default_nettype wire
